/* core/uisl_params.svh */
/*
 * Constants of the interrupt source level and event latch block:
 * register offsets, field positions, widths and the id settle time.
 * Assumes it is included by bare name from the package and modules.
 */
`ifndef UISL_PARAMS_SVH
`define UISL_PARAMS_SVH

`define UISL_ADDR_W          8
`define UISL_DATA_W          8
`define UISL_ADDR_LEVELS     8'h13
`define UISL_ADDR_LATCH      8'h14
`define UISL_NSRC            5
`define UISL_BIT_ID          4
`define UISL_BIT_SESS_END    3
`define UISL_BIT_SESS_VALID  2
`define UISL_BIT_BUS_POWER   1
`define UISL_BIT_HOST_DISC   0
`define UISL_CLK_HZ          50000000
`define UISL_ID_HOLD_MS      50
`define UISL_ID_HOLD_CYCLES  ((`UISL_CLK_HZ / 1000) * `UISL_ID_HOLD_MS)
`define UISL_TMR_W           22

`endif

/* core/uisl_pkg.sv */
/*
 * Types shared by the level and latch modules.
 * Assumes uisl_params.svh is on the include path.
 */
`default_nettype none
`include "uisl_params.svh"

package uisl_pkg;
    // One bit per interrupt source, id at the top
    typedef logic [`UISL_NSRC-1:0] uisl_src_t;

    // Whole state of the top module
    typedef struct packed {
        uisl_src_t                status;  // Levels as reported
        uisl_src_t                latch;   // Sticky events
        logic [`UISL_DATA_W-1:0]  rdata;   // Read answer
        logic                     rvalid;  // Read answer strobe
        logic                     lpm_d;   // Low power, last cycle
        logic                     ser_d;   // Serial mode, last cycle
        logic                     car_d;   // Car-kit mode, last cycle
        logic                     pull_d;  // Id pull-up, last cycle
        logic [`UISL_TMR_W-1:0]   timer;   // Id settle countdown
    } uisl_state_t;
endpackage

`default_nettype wire

/* core/uisl_ev_if.sv */
/*
 * Carrier between the top and the change detector.
 * Assumes both ends sit in one clock domain.
 */
`default_nettype none

interface uisl_ev_if
    import uisl_pkg::*;
();
    uisl_src_t cur;      // Levels this cycle
    uisl_src_t prev;     // Levels last cycle
    uisl_src_t rise_en;  // Rising edge enables
    uisl_src_t fall_en;  // Falling edge enables
    uisl_src_t events;   // Unmasked changes

    modport top_side  (output cur, output prev, output rise_en, output fall_en,
                       input events);
    modport edge_side (input cur, input prev, input rise_en, input fall_en,
                       output events);
endinterface

`default_nettype wire

/* core/uisl_edge.sv */
/*
 * Change detector: flags unmasked rising and falling edges per source.
 * Assumes prev is the registered copy of cur.
 */
`default_nettype none

module uisl_edge
    import uisl_pkg::*;
(
    // Level pairs and enables in, events out
    uisl_ev_if.edge_side ev
);
    // Rising needs its rise enable, falling its fall enable
    assign ev.events = (ev.cur & ~ev.prev & ev.rise_en)
                     | (~ev.cur & ev.prev & ev.fall_en);
endmodule

`default_nettype wire

/* core/uisl_top.sv */
/*
 * Interrupt source level register and event latch register.
 * Assumes the register port delivers one-cycle read and write strobes
 * synchronous to clk, and that source levels are already synchronous.
 */
`default_nettype none
`include "uisl_params.svh"

module uisl_top
    import uisl_pkg::*;
#(
    parameter int ID_HOLD_CYCLES = `UISL_ID_HOLD_CYCLES  // Id settle time in cycles
)(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Register port
    input  wire logic                    reg_rd,
    input  wire logic                    reg_wr,
    input  wire logic [`UISL_ADDR_W-1:0] reg_addr,
    output logic      [`UISL_DATA_W-1:0] reg_rdata,
    output logic                         reg_rvalid,
    // Source levels
    input  wire logic                    id_ground_detect,
    input  wire logic                    session_end_level,
    input  wire logic                    session_valid_level,
    input  wire logic                    bus_power_valid,
    input  wire logic                    host_disconnect_level,
    // Edge enables, one bit per source
    input  wire logic [`UISL_NSRC-1:0]   rise_enable,
    input  wire logic [`UISL_NSRC-1:0]   fall_enable,
    // Mode controls
    input  wire logic                    id_pullup_enable,
    input  wire logic                    plus_line_pulldown,
    input  wire logic                    minus_line_pulldown,
    input  wire logic                    low_power_mode,
    input  wire logic                    serial_mode,
    input  wire logic                    carkit_mode
);
    uisl_state_t st;        // Registered state
    uisl_state_t next_st;   // Next state
    uisl_ev_if   ev ();     // Change detector link
    uisl_src_t   cur;       // Levels as reported this cycle
    logic        host_mode; // Both pull-downs on
    logic        id_frozen; // Id level must not update
    logic        lpm_entry; // Low power mode just entered
    logic        mode_entry;// Serial or car-kit just entered
    logic        rd_levels; // Read of the level register
    logic        rd_latch;  // Read of the latch register

    localparam logic [`UISL_TMR_W-1:0] HOLD = `UISL_TMR_W'(ID_HOLD_CYCLES);
    localparam int PAD = `UISL_DATA_W - `UISL_NSRC;

    // Address match for one of our two registers
    function automatic logic addr_hit(input logic [`UISL_ADDR_W-1:0] a,
                                      input logic [`UISL_ADDR_W-1:0] t);
        addr_hit = (a == t);
    endfunction

    // Change detector
    uisl_edge u_edge (
        .ev (ev)
    );

    assign ev.cur     = cur;
    assign ev.prev    = st.status;
    assign ev.rise_en = rise_enable;
    assign ev.fall_en = fall_enable;

    // Qualifiers of the current cycle
    always_comb begin
        host_mode  = plus_line_pulldown & minus_line_pulldown;
        // Freeze covers the enabling cycle itself, before the timer loads
        id_frozen  = !id_pullup_enable || !st.pull_d || (st.timer != '0);
        lpm_entry  = low_power_mode & ~st.lpm_d;
        mode_entry = (serial_mode & ~st.ser_d) | (carkit_mode & ~st.car_d);
        // A write strobe wins, so a write never clears the latch
        rd_levels  = reg_rd & ~reg_wr & addr_hit(reg_addr, `UISL_ADDR_LEVELS);
        rd_latch   = reg_rd & ~reg_wr & addr_hit(reg_addr, `UISL_ADDR_LATCH);
    end

    // Reported levels
    always_comb begin
        cur = st.status;
        cur[`UISL_BIT_SESS_END]   = session_end_level;
        cur[`UISL_BIT_SESS_VALID] = session_valid_level;
        cur[`UISL_BIT_BUS_POWER]  = bus_power_valid;
        if (!id_frozen) begin
            cur[`UISL_BIT_ID] = id_ground_detect;
        end
        // Low power zeroes the disconnect level; else outside host mode it is held, not tracked
        if (low_power_mode) begin
            cur[`UISL_BIT_HOST_DISC] = 1'b0;
        end else if (host_mode) begin
            cur[`UISL_BIT_HOST_DISC] = host_disconnect_level;
        end
    end

    // Next state
    always_comb begin
        next_st        = st;
        next_st.status = cur;
        next_st.lpm_d  = low_power_mode;
        next_st.ser_d  = serial_mode;
        next_st.car_d  = carkit_mode;
        next_st.pull_d = id_pullup_enable;
        next_st.rvalid = rd_levels | rd_latch;
        // Id settle countdown
        if (!id_pullup_enable) begin
            next_st.timer = '0;
        end else if (!st.pull_d) begin
            next_st.timer = HOLD;
        end else if (st.timer != '0) begin
            next_st.timer = st.timer - 1'b1;
        end
        // Mode entries clear; a same-cycle event still survives
        if (lpm_entry || mode_entry) begin
            next_st.latch = '0;
        end
        if (rd_latch) begin
            // Event in the read cycle goes out in the data only
            next_st.rdata = {{PAD{1'b0}}, st.latch | ev.events};
            next_st.latch = '0;
        end else begin
            next_st.latch = next_st.latch | ev.events;
        end
        if (rd_levels) begin
            next_st.rdata = {{PAD{1'b0}}, st.status};
        end
        // Disconnect level and its latch bit start from the attach state
        if (reset) begin
            next_st = '0;
            next_st.status[`UISL_BIT_HOST_DISC] = host_disconnect_level;
            next_st.latch[`UISL_BIT_HOST_DISC]  = host_disconnect_level;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign reg_rdata  = st.rdata;
    assign reg_rvalid = st.rvalid;

    // Checks
    property p_levels_read;
        @(posedge clk) disable iff (reset)
        rd_levels |=> reg_rvalid && (reg_rdata == {{PAD{1'b0}}, $past(st.status)});
    endproperty
    a_levels_read: assert property (p_levels_read) else $error("level read wrong");

    property p_id_freeze;
        @(posedge clk) disable iff (reset)
        !id_pullup_enable |=> $stable(st.status[`UISL_BIT_ID]);
    endproperty
    a_id_freeze: assert property (p_id_freeze) else $error("id level moved");

    property p_id_hold;
        @(posedge clk) disable iff (reset)
        $rose(id_pullup_enable) |=> (st.timer == HOLD);
    endproperty
    a_id_hold: assert property (p_id_hold) else $error("id timer not loaded");

    property p_hd_lpm;
        @(posedge clk) disable iff (reset)
        low_power_mode |=> !st.status[`UISL_BIT_HOST_DISC];
    endproperty
    a_hd_lpm: assert property (p_hd_lpm) else $error("disconnect not zero");

    property p_hd_reset;
        @(posedge clk)
        reset |=> (st.status[`UISL_BIT_HOST_DISC] == $past(host_disconnect_level))
              && (st.latch[`UISL_BIT_HOST_DISC] == $past(host_disconnect_level));
    endproperty
    a_hd_reset: assert property (p_hd_reset) else $error("disconnect reset wrong");

    property p_latch_set;
        @(posedge clk) disable iff (reset)
        (ev.events != '0) && !rd_latch |=> ((st.latch & $past(ev.events)) == $past(ev.events));
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("event not latched");

    property p_read_clear;
        @(posedge clk) disable iff (reset)
        rd_latch |=> (st.latch == '0) && reg_rvalid
                  && (reg_rdata == {{PAD{1'b0}}, $past(st.latch | ev.events)});
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("latch read wrong");

    property p_mode_clear;
        @(posedge clk) disable iff (reset)
        (lpm_entry || mode_entry) && (ev.events == '0) |=> (st.latch == '0);
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("latch not cleared");

    property p_host_gate;
        @(posedge clk) disable iff (reset)
        !host_mode && !low_power_mode |=> $stable(st.status[`UISL_BIT_HOST_DISC]);
    endproperty
    a_host_gate: assert property (p_host_gate) else $error("disconnect moved");

    property p_fall_mask;
        @(posedge clk) disable iff (reset)
        st.status[`UISL_BIT_BUS_POWER] && !cur[`UISL_BIT_BUS_POWER]
            && !fall_enable[`UISL_BIT_BUS_POWER] |-> !ev.events[`UISL_BIT_BUS_POWER];
    endproperty
    a_fall_mask: assert property (p_fall_mask) else $error("masked fall seen");

    property p_upper_zero;
        @(posedge clk) disable iff (reset)
        reg_rvalid |-> (reg_rdata[`UISL_DATA_W-1:`UISL_NSRC] == '0);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    // Main scenarios
    c_read_event: cover property (@(posedge clk) disable iff (reset)
        rd_latch && (ev.events != '0));
    c_id_release: cover property (@(posedge clk) disable iff (reset)
        (st.timer == 1) ##1 (st.timer == 0));
    c_lpm_entry: cover property (@(posedge clk) disable iff (reset)
        lpm_entry && (st.latch != '0));
endmodule

`default_nettype wire

/* verif/uisl_link_model.sv */
/*
 * Link-side model: issues single-byte register reads and writes.
 * Assumes it shares clk with the block and that tb calls its tasks.
 */
`default_nettype none
`include "uisl_params.svh"

module uisl_link_model (
    // Clock
    input  wire logic                    clk,
    // Register port toward the block
    output var  logic                    reg_rd,
    output var  logic                    reg_wr,
    output var  logic [`UISL_ADDR_W-1:0] reg_addr,
    input  wire logic [`UISL_DATA_W-1:0] reg_rdata,
    input  wire logic                    reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        reg_rd   = 1'b0;
        reg_wr   = 1'b0;
        reg_addr = 8'h00;
    end

    // Latch reads only when the bench asks, none on its own
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        // Parked off the mapped offsets so a stale address means nothing
        reg_addr <= ~a;
        #1;
        v = reg_rvalid;
        d = reg_rdata;
    endtask

    // One-cycle write strobe, no answer expected
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_wr   <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

`default_nettype wire

/* verif/tb.sv */
/*
 * Self-checking bench for the level and latch registers.
 * Assumes uisl_top and the link model compile alongside it.
 */
`default_nettype none
`include "uisl_params.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // Clock, reset and design inputs
    logic       clk = 0, reset = 1;
    logic       id_ground_detect = 0, session_end_level = 0, session_valid_level = 0;
    logic       bus_power_valid = 0, host_disconnect_level = 1;
    logic [4:0] rise_enable = 5'h00, fall_enable = 5'h1F;
    logic       id_pullup_enable = 0, plus_line_pulldown = 0, minus_line_pulldown = 0;
    logic       low_power_mode = 0, serial_mode = 0, carkit_mode = 0;
    // Register port
    logic       reg_rd, reg_wr, reg_rvalid;
    logic [7:0] reg_addr, reg_rdata, d;
    logic       v;
    int         mismatches = 0, cmp_count = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    // Short id settle time keeps the run brief
    uisl_top #(.ID_HOLD_CYCLES(8)) dut (.clk, .reset, .reg_rd, .reg_wr, .reg_addr,
        .reg_rdata, .reg_rvalid, .id_ground_detect, .session_end_level,
        .session_valid_level, .bus_power_valid, .host_disconnect_level, .rise_enable,
        .fall_enable, .id_pullup_enable, .plus_line_pulldown, .minus_line_pulldown,
        .low_power_mode, .serial_mode, .carkit_mode);

    uisl_link_model link (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_rdata, .reg_rvalid);

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Read one register and compare strobe and byte
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] q;
        logic       ok;
        link.rd(a, q, ok);
        `CHK(nm, 1'b1, ok)
        `CHK(nm, e, q)
    endtask

    // Single closing point of the run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #(20 * 3000);
        mismatches++;
        end_of_test();
    end

    // Test sequence
    initial begin
        cyc(20);
        reset <= 1'b0;
        // No host attached: disconnect bit comes out of reset set
        rdc(8'h13, 8'h01, "levels after reset");
        rdc(8'h14, 8'h01, "latch after reset");
        rdc(8'h14, 8'h00, "latch after read");
        // Rising edges masked, levels still shown
        @(posedge clk) {session_end_level, session_valid_level, bus_power_valid} <= 3'b111;
        cyc(3);
        rdc(8'h13, 8'h0F, "levels");
        rdc(8'h14, 8'h00, "masked rise");
        @(posedge clk) {session_end_level, session_valid_level, bus_power_valid} <= 3'b000;
        cyc(3);
        rdc(8'h14, 8'h0E, "falls latched");
        rdc(8'h14, 8'h00, "latch re-read");
        // Writes and unmapped reads change nothing
        link.wr(8'h13, 8'hFF);
        link.wr(8'h14, 8'hFF);
        rdc(8'h13, 8'h01, "levels after write");
        rdc(8'h14, 8'h00, "latch after write");
        link.rd(8'h15, d, v);
        `CHK("unmapped strobe", 1'b0, v)
        // Event in the very cycle of the latch read
        @(posedge clk) rise_enable <= 5'h02;
        fork
            link.rd(8'h14, d, v);
            begin @(posedge clk) bus_power_valid <= 1'b1; end
        join
        `CHK("same-cycle data", 8'h02, d)
        rdc(8'h14, 8'h00, "same-cycle latch");
        @(posedge clk) bus_power_valid <= 1'b0;
        cyc(3);
        rdc(8'h14, 8'h02, "fall latched");
        // Each mode entry wipes a pending event
        @(posedge clk) begin fall_enable <= 5'h00; rise_enable <= 5'h08; end
        for (int m = 0; m < 3; m++) begin
            @(posedge clk) session_end_level <= 1'b1;
            cyc(3);
            @(posedge clk) {low_power_mode, serial_mode, carkit_mode} <= 3'b100 >> m;
            cyc(3);
            if (m == 0) rdc(8'h13, 8'h08, "levels in low power");
            @(posedge clk) begin
                {low_power_mode, serial_mode, carkit_mode} <= 3'b000;
                session_end_level <= 1'b0;
            end
            cyc(3);
            rdc(8'h14, 8'h00, "latch after mode entry");
        end
        // Host mode follows the level, otherwise it is held
        @(posedge clk) begin
            {plus_line_pulldown, minus_line_pulldown} <= 2'b11;
            host_disconnect_level <= 1'b0;
        end
        cyc(3);
        rdc(8'h13, 8'h00, "host mode level low");
        @(posedge clk) host_disconnect_level <= 1'b1;
        cyc(3);
        rdc(8'h13, 8'h01, "host mode level high");
        @(posedge clk) begin minus_line_pulldown <= 1'b0; host_disconnect_level <= 1'b0; end
        cyc(3);
        rdc(8'h13, 8'h01, "held outside host mode");
        // Id level frozen until pull-up on and settled
        @(posedge clk) id_ground_detect <= 1'b1;
        cyc(3);
        rdc(8'h13, 8'h01, "id frozen pull-up off");
        @(posedge clk) id_pullup_enable <= 1'b1;
        cyc(2);
        rdc(8'h13, 8'h01, "id frozen settling");
        cyc(14);
        rdc(8'h13, 8'h11, "id settled");
        // Bus power fall with its fall enable clear must latch nothing
        @(posedge clk) bus_power_valid <= 1'b1;
        cyc(3);
        @(posedge clk) bus_power_valid <= 1'b0;
        cyc(3);
        rdc(8'h14, 8'h00, "masked fall");
        // Mid-run reset with a host attached: disconnect bits start clear
        @(posedge clk) reset <= 1'b1;
        cyc(2);
        @(posedge clk) reset <= 1'b0;
        rdc(8'h13, 8'h00, "levels after host reset");
        rdc(8'h14, 8'h00, "latch after host reset");
        end_of_test();
    end
endmodule

`default_nettype wire
